// ---- shared/fpi_defines.vh ----
`ifndef FPI_DEFINES_VH
`define FPI_DEFINES_VH

// Clock and start-up timeout
`define FPI_CLK_HZ 32'd100000000
`define FPI_CFG_TIMEOUT_S 32'd30

// Start-up states
`define FPI_ST_SAMPLE 2'h0
`define FPI_ST_WAIT 2'h1
`define FPI_ST_RUN 2'h2

// Process image geometry
`define FPI_IO_MAX 8'h80
`define FPI_IO_BASIC 8'h18
`define FPI_BYTES 5'h10
`define FPI_STAT_IDX_BASIC 5'h03
`define FPI_STAT_IDX_EXT 5'h10

// Status byte fields
`define FPI_SB_OUT_FAULT 0
`define FPI_SB_IN_FAULT 1
`define FPI_SB_FAULT 2
`define FPI_SB_DIAGNOSTIC 3
`define FPI_SB_RUN 4
`define FPI_SB_XCHG 5

// Rotary switch decoding
`define FPI_DIGIT_MAX 4'h9
`define FPI_TENS_WEIGHT 7'h0A
`define FPI_RATE_W 10
`define FPI_RATE_1 10'h00A
`define FPI_RATE_2 10'h014
`define FPI_RATE_3 10'h032
`define FPI_RATE_4 10'h07D
`define FPI_RATE_5 10'h0FA
`define FPI_RATE_6 10'h1F4
`define FPI_RATE_7 10'h320
`define FPI_RATE_8 10'h3E8

// Register word indices (address bits 4:2)
`define FPI_REG_CTRL 3'h0
`define FPI_REG_STATUS 3'h1
`define FPI_REG_SWITCH 3'h2
`define FPI_REG_COUNT 3'h3
`define FPI_REG_ID 3'h4

// Register fields and reset values
`define FPI_CTRL_XCHG_EN 0
`define FPI_CTRL_RESET 1'h1
// Arbitrary identification value
`define FPI_ID_VALUE 32'h00A5_0001

// AXI responses
`define FPI_RESP_OKAY 2'h0
`define FPI_RESP_SLVERR 2'h2

`endif

// ---- rtl/fpi_top.v ----
`include "fpi_defines.vh"

module fpi_top #(
  parameter [31:0] CFG_TIMEOUT_CYC = `FPI_CFG_TIMEOUT_S * `FPI_CLK_HZ,
  parameter [31:0] ID_VALUE = `FPI_ID_VALUE
)
(
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fb_wr_valid,
  input wire [4:0] fb_wr_idx,
  input wire [7:0] fb_wr_data,
  input wire fb_rd_valid,
  input wire [4:0] fb_rd_idx,
  output reg [7:0] fb_rd_data,
  output reg fb_rd_ack,
  input wire cfg_valid,
  input wire [7:0] cfg_io_count,
  output wire [127:0] virt_in,
  input wire [127:0] virt_out,
  input wire output_fault_led,
  input wire input_fault_led,
  input wire fault_led,
  input wire diagnostic_led,
  input wire run_led,
  input wire [3:0] rate_select_switch,
  input wire [3:0] tens_digit_switch,
  input wire [3:0] ones_digit_switch,
  output reg [6:0] node_id,
  output reg node_valid,
  output reg [`FPI_RATE_W-1:0] bit_rate_kbps,
  output reg rate_valid,
  output wire operational,
  output reg ext_error
);

  localparam ST_SAMPLE = `FPI_ST_SAMPLE;
  localparam ST_WAIT = `FPI_ST_WAIT;
  localparam ST_RUN = `FPI_ST_RUN;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] tmo_cnt_q;
  reg cfg_ok_q;
  reg timeout_q;
  reg [7:0] io_count_q;
  reg ctrl_xchg_en_q;
  reg [7:0] in_mem [0:15];
  reg [`FPI_RATE_W-1:0] rate_dec;
  reg rate_ok;
  wire [127:0] out_masked;
  wire [127:0] in_flat;
  wire xchg_active;
  wire ext_mode;
  wire [4:0] stat_idx;
  wire [7:0] status_byte;
  wire [6:0] node_calc;

  assign operational = (state_q == ST_RUN);
  assign xchg_active = operational & cfg_ok_q & ctrl_xchg_en_q;
  assign ext_mode = (io_count_q > `FPI_IO_BASIC);
  assign stat_idx = ext_mode ? `FPI_STAT_IDX_EXT : `FPI_STAT_IDX_BASIC;

  // Start-up sequencing
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_SAMPLE:
      begin
        state_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cfg_valid || (tmo_cnt_q >= CFG_TIMEOUT_CYC - 32'h1))
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_SAMPLE;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_SAMPLE;
      tmo_cnt_q <= 32'h0;
      cfg_ok_q <= 1'b0;
      timeout_q <= 1'b0;
      io_count_q <= 8'h0;
      ext_error <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ext_error <= 1'b0;
      if (state_q == ST_WAIT)
      begin
        tmo_cnt_q <= tmo_cnt_q + 32'h1;
      end
      if ((state_q == ST_WAIT) && !cfg_valid && (state_d == ST_RUN))
      begin
        timeout_q <= 1'b1;
        ext_error <= 1'b1;
      end
      if (cfg_valid && (state_q != ST_SAMPLE))
      begin
        cfg_ok_q <= 1'b1;
        if (cfg_io_count > `FPI_IO_MAX)
        begin
          io_count_q <= `FPI_IO_MAX;
        end
        else
        begin
          io_count_q <= cfg_io_count;
        end
      end
    end
  end

  // Switch decoding
  assign node_calc = {3'h0, tens_digit_switch} * `FPI_TENS_WEIGHT
                   + {3'h0, ones_digit_switch};

  always @*
  begin
    rate_ok = 1'b1;
    case (rate_select_switch)
      4'h1: rate_dec = `FPI_RATE_1;
      4'h2: rate_dec = `FPI_RATE_2;
      4'h3: rate_dec = `FPI_RATE_3;
      4'h4: rate_dec = `FPI_RATE_4;
      4'h5: rate_dec = `FPI_RATE_5;
      4'h6: rate_dec = `FPI_RATE_6;
      4'h7: rate_dec = `FPI_RATE_7;
      4'h8: rate_dec = `FPI_RATE_8;
      default:
      begin
        rate_dec = {`FPI_RATE_W{1'b0}};
        rate_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      node_id <= 7'h0;
      node_valid <= 1'b0;
      bit_rate_kbps <= {`FPI_RATE_W{1'b0}};
      rate_valid <= 1'b0;
    end
    else if (state_q == ST_SAMPLE)
    begin
      node_id <= node_calc;
      node_valid <= (tens_digit_switch <= `FPI_DIGIT_MAX)
                  && (ones_digit_switch <= `FPI_DIGIT_MAX);
      bit_rate_kbps <= rate_dec;
      rate_valid <= rate_ok;
    end
  end

  // Image bit mapping
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi = gi + 1)
    begin : g_map
      assign in_flat[gi] = in_mem[gi / 8][gi % 8];
      assign virt_in[gi] = (gi < io_count_q) & in_flat[gi];
      assign out_masked[gi] = (gi < io_count_q) & virt_out[gi];
    end
  endgenerate

  assign status_byte = {2'h0,
                        xchg_active,
                        run_led,
                        diagnostic_led,
                        fault_led,
                        input_fault_led,
                        output_fault_led};

  // Fieldbus side: only ever answers
  integer k;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (k = 0; k < 16; k = k + 1)
      begin
        in_mem[k] <= 8'h0;
      end
      fb_rd_data <= 8'h0;
      fb_rd_ack <= 1'b0;
    end
    else
    begin
      fb_rd_ack <= 1'b0;
      if (fb_wr_valid && operational && (fb_wr_idx < `FPI_BYTES))
      begin
        in_mem[fb_wr_idx[3:0]] <= fb_wr_data;
      end
      if (fb_rd_valid && operational)
      begin
        fb_rd_ack <= 1'b1;
        if (fb_rd_idx == stat_idx)
        begin
          fb_rd_data <= status_byte;
        end
        else if (fb_rd_idx < `FPI_BYTES)
        begin
          fb_rd_data <= out_masked[{fb_rd_idx[3:0], 3'h0} +: 8];
        end
        else
        begin
          fb_rd_data <= 8'h0;
        end
      end
    end
  end

  // Register bus slave
  reg aw_have_q;
  reg w_have_q;
  reg [2:0] aw_idx_q;
  reg aw_map_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_word;
  reg rd_hit;
  wire [2:0] ar_idx;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx = s_axi_araddr[4:2];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 3'h0;
      aw_map_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPI_RESP_OKAY;
      ctrl_xchg_en_q <= `FPI_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[4:2];
        aw_map_q <= (s_axi_awaddr[31:5] == 27'h0)
                  && (s_axi_awaddr[4:2] <= `FPI_REG_ID);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_map_q ? `FPI_RESP_OKAY : `FPI_RESP_SLVERR;
        if (aw_map_q && (aw_idx_q == `FPI_REG_CTRL) && wstrb_q[0])
        begin
          ctrl_xchg_en_q <= wdata_q[`FPI_CTRL_XCHG_EN];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @*
  begin
    rd_word = 32'h0;
    rd_hit = (s_axi_araddr[31:5] == 27'h0);
    case (ar_idx)
      `FPI_REG_CTRL: rd_word = {31'h0, ctrl_xchg_en_q};
      `FPI_REG_STATUS: rd_word = {26'h0, node_valid, rate_valid, timeout_q,
                                  xchg_active, cfg_ok_q, operational};
      `FPI_REG_SWITCH: rd_word = {14'h0, bit_rate_kbps, 1'b0, node_id};
      `FPI_REG_COUNT: rd_word = {24'h0, io_count_q};
      `FPI_REG_ID: rd_word = ID_VALUE;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FPI_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_word : 32'h0;
      s_axi_rresp <= rd_hit ? `FPI_RESP_OKAY : `FPI_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fpi_top

// ---- tb/fpi_top_asserts.sv ----
module fpi_top_asserts (
  input logic aclk,
  input logic aresetn,
  input logic fb_rd_valid,
  input logic fb_rd_ack,
  input logic operational,
  input logic ext_error,
  input logic rate_valid,
  input logic [6:0] node_id,
  input logic [9:0] bit_rate_kbps,
  input logic [3:0] tens_digit_switch,
  input logic [3:0] ones_digit_switch
);
  timeunit 1ns / 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd;
    fb_rd_valid && operational;
  endsequence
  sequence s_rel;
    $rose(aresetn);
  endsequence
  property p_ack; s_rd |=> fb_rd_ack; endproperty
  property p_noack; fb_rd_ack |-> $past(fb_rd_valid) && $past(operational); endproperty
  property p_err; ext_error |-> $rose(operational); endproperty
  property p_pulse; ext_error |=> !ext_error; endproperty
  property p_stay; operational |=> operational; endproperty
  property p_hold; operational |-> $stable(node_id) && $stable(bit_rate_kbps); endproperty
  property p_rate; rate_valid == (bit_rate_kbps != 10'h000); endproperty
  property p_id; s_rel |-> ##2 node_id == tens_digit_switch * 10 + ones_digit_switch; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  a_noack: assert property (p_noack) else $error("answer without read");
  a_err: assert property (p_err) else $error("error report off start");
  a_pulse: assert property (p_pulse) else $error("error report too long");
  a_stay: assert property (p_stay) else $error("run state lost");
  a_hold: assert property (p_hold) else $error("switch value moved");
  a_rate: assert property (p_rate) else $error("rate flag wrong");
  a_id: assert property (p_id) else $error("node id wrong");
endmodule // fpi_top_asserts

bind fpi_top fpi_top_asserts chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .fb_rd_valid(fb_rd_valid),
  .fb_rd_ack(fb_rd_ack),
  .operational(operational),
  .ext_error(ext_error),
  .rate_valid(rate_valid),
  .node_id(node_id),
  .bit_rate_kbps(bit_rate_kbps),
  .tens_digit_switch(tens_digit_switch),
  .ones_digit_switch(ones_digit_switch)
);

// ---- tb/fpi_master.sv ----
module fpi_master (
  input logic aclk,
  output logic fb_wr_valid,
  output logic [4:0] fb_wr_idx,
  output logic [7:0] fb_wr_data,
  output logic fb_rd_valid,
  output logic [4:0] fb_rd_idx,
  input logic [7:0] fb_rd_data,
  input logic fb_rd_ack
);
  timeunit 1ns / 100ps;
  initial
  begin
    fb_wr_valid = 1'h0;
    fb_rd_valid = 1'h0;
    fb_wr_idx = 5'h0;
    fb_wr_data = 8'h0;
    fb_rd_idx = 5'h0;
  end
  // Input byte delivery, lines inverted once released
  task wr(input logic [4:0] i, input logic [7:0] v);
    @(posedge aclk);
    fb_wr_valid <= 1'h1;
    fb_wr_idx <= i;
    fb_wr_data <= v;
    @(posedge aclk);
    fb_wr_valid <= 1'h0;
    fb_wr_idx <= ~i;
    fb_wr_data <= ~v;
  endtask
  // Output byte fetch
  task rd(input logic [4:0] i, output logic [7:0] v, output logic k);
    @(posedge aclk);
    fb_rd_valid <= 1'h1;
    fb_rd_idx <= i;
    @(posedge aclk);
    fb_rd_valid <= 1'h0;
    fb_rd_idx <= ~i;
    #1;
    v = fb_rd_data;
    k = fb_rd_ack;
  endtask
endmodule // fpi_master

// ---- tb/fieldbus_process_image_test.sv ----
module fieldbus_process_image_test;
  timeunit 1ns / 100ps;
  logic aclk = 1'h0, aresetn = 1'h0, cfg_valid = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] cfg_io_count = 8'h0;
  logic [127:0] virt_out = 128'h0;
  logic output_fault_led = 1'h0, input_fault_led = 1'h0, fault_led = 1'h0;
  logic diagnostic_led = 1'h0, run_led = 1'h0;
  logic [3:0] rate_select_switch = 4'h0, tens_digit_switch = 4'h0, ones_digit_switch = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire fb_wr_valid, fb_rd_valid, fb_rd_ack, node_valid, rate_valid, operational, ext_error;
  wire [4:0] fb_wr_idx, fb_rd_idx;
  wire [7:0] fb_wr_data, fb_rd_data;
  wire [127:0] virt_in;
  wire [6:0] node_id;
  wire [9:0] bit_rate_kbps;
  int mismatches = 0, cmp_count = 0, n;
  logic [7:0] d;
  logic a;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [9:0] kb [10] = '{10'h0, 10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA, 10'h1F4,
    10'h320, 10'h3E8, 10'h0};
  fpi_top #(.CFG_TIMEOUT_CYC(32'h32)) dut_u (.*);
  fpi_master mst_u (.*);
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task rst;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  task upcount;
    n = 0;
    while (operational !== 1'h1 && n < 99)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
  endtask
  task cfg(input logic [7:0] c);
    @(posedge aclk);
    cfg_valid <= 1'h1;
    cfg_io_count <= c;
    @(posedge aclk);
    cfg_valid <= 1'h0;
  endtask
  task axw(input logic [31:0] ad, input logic [31:0] dt);
    logic pa, pw, ka, kw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (pa || pw)
    begin
      @(negedge aclk);
      ka = pa && s_axi_awready;
      kw = pw && s_axi_wready;
      @(posedge aclk);
      if (ka)
        s_axi_awvalid <= 1'h0;
      if (kw)
        s_axi_wvalid <= 1'h0;
      pa = pa && !ka;
      pw = pw && !kw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    @(posedge aclk);
  endtask
  task axr(input logic [31:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
  endtask
  task rdx(input logic [4:0] i, input logic [7:0] e);
    mst_u.rd(i, d, a);
    chk({a, d}, {1'h1, e});
  endtask
  task t_switch;
    for (int c = 0; c < 10; c++)
    begin
      @(posedge aclk);
      rate_select_switch <= 4'(c);
      tens_digit_switch <= 4'(c);
      ones_digit_switch <= 4'(9 - c);
      rst;
      repeat (3) @(posedge aclk);
      #1;
      chk(bit_rate_kbps, kb[c]);
      chk(rate_valid, kb[c] != 10'h0);
      chk(node_id, 9 * c + 9);
      chk(node_valid, 1'h1);
      mst_u.rd(5'h0, d, a);
      chk(a, 1'h0);
    end
    @(posedge aclk);
    rate_select_switch <= 4'h5;
    tens_digit_switch <= 4'h0;
    repeat (3) @(posedge aclk);
    #1;
    chk({bit_rate_kbps, node_id}, {10'h0, 7'h5A});
  endtask
  task t_timeout;
    rst;
    upcount;
    chk(n, 51);
    chk(ext_error, 1'h1);
  endtask
  task t_map;
    @(posedge aclk);
    virt_out <= ~128'h3CA57E;
    cfg(8'h18);
    mst_u.wr(5'h1, 8'h10);
    #1;
    chk(virt_in[12], 1'h1);
    mst_u.wr(5'h0, 8'hA5);
    mst_u.wr(5'h2, 8'h3C);
    mst_u.wr(5'h3, 8'hFF);
    #1;
    chk(virt_in[31:0], 32'h003C10A5);
    for (int i = 0; i < 3; i++)
      rdx(5'(i), 8'(24'hC35A81 >> 8 * i));
    for (int k = 0; k < 5; k++)
    begin
      @(posedge aclk);
      {run_led, diagnostic_led, fault_led, input_fault_led, output_fault_led} <= 5'h1 << k;
      rdx(5'h3, 8'h20 | (8'h1 << k));
    end
    axw(32'h0, 32'h0);
    rdx(5'h3, 8'h10);
    cfg(8'h14);
    rdx(5'h2, 8'h03);
    cfg(8'h20);
    rdx(5'h3, 8'hFF);
    rdx(5'h10, 8'h10);
  endtask
  task t_regs;
    axw(32'h8, 32'hFFFFFFFF);
    chk(rs, 2'h0);
    axr(32'h8);
    chk(rv, 32'h0000FA00);
    axr(32'h14);
    chk(rs, 2'h2);
    axw(32'h14, 32'h0);
    chk(rs, 2'h2);
    axr(32'h4);
    chk(rv, 32'h0000003B);
    axr(32'h0);
    chk(rv, 32'h0);
  endtask
  task t_cfg;
    @(posedge aclk);
    cfg_valid <= 1'h1;
    tens_digit_switch <= 4'hC;
    rst;
    upcount;
    chk(n, 2);
    chk(ext_error, 1'h0);
    chk(node_valid, 1'h0);
    chk(node_id, 7'h78);
  endtask
  initial
  begin
    t_switch;
    t_timeout;
    t_map;
    t_regs;
    t_cfg;
    wrap_up;
  end
  initial
  begin
    #100000;
    mismatches++;
    wrap_up;
  end
endmodule // fieldbus_process_image_test
